//--- countdown_if.sv
// Signals shared by a sequencer, its second tick and its countdown
`timescale 1ns/1ps
interface countdown_if;
  logic load;
  logic [supervisor_pkg::VAL_W-1:0] load_val;
  logic run;
  logic tick;
  logic expired;

  modport ctrl (output load, output load_val, output run, input expired);
  modport ticker (input load, output tick);
  modport timer (input load, input load_val, input run, input tick, output expired);
endinterface

//--- countdown_timer.sv
// Seconds countdown with load, hold and expiry pulse
`timescale 1ns/1ps
module countdown_timer (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  countdown_if.timer cd // Load, run and tick in, expiry out
);
  logic [supervisor_pkg::VAL_W-1:0] count_r;
  logic step;

  assign step = cd.run && cd.tick && (count_r != '0);

  // Count down one per tick while running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (cd.load) begin
      count_r <= cd.load_val;
    end else if (step) begin
      count_r <= count_r - 1'b1;
    end
  end

  // One-cycle pulse as the count reaches zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cd.expired <= 1'b0;
    end else begin
      cd.expired <= step && (count_r == 16'h0001) && !cd.load;
    end
  end
endmodule

//--- host_model.sv
// Host computer model that counts power-button events
`timescale 1ns/1ps
module host_model (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic pwr_en, // Host supply present
  input wire logic evt, // Power-button event pulse
  output logic [7:0] evt_cnt // Events taken while powered
);
  // A host without supply cannot notice a button event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_cnt <= 8'h00;
    end else if (evt && pwr_en) begin
      evt_cnt <= evt_cnt + 8'h01;
    end
  end
endmodule

//--- second_tick.sv
// One-second enable pulse, restarted whenever a countdown is loaded
`timescale 1ns/1ps
module second_tick #(
  parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  countdown_if.ticker cd // Load in, tick out
);
  localparam int CNT_W = $clog2(TICK_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;

  // Prescaler, so the first tick falls a whole second after load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      cd.tick <= 1'b0;
    end else if (cd.load) begin
      cnt_r <= '0;
      cd.tick <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      cd.tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      cd.tick <= 1'b0;
    end
  end
endmodule

//--- supervisor_pkg.sv
// Constants, defaults and state types of the vehicle power supervisor
package supervisor_pkg;

  // Clock and one-second tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1_000_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Widths
  localparam int VAL_W = 16;
  localparam int SEL_W = 3;

  // Parameter select codes on the configuration port
  localparam logic [SEL_W-1:0] SEL_POWER_ON_WAIT = 3'h0;
  localparam logic [SEL_W-1:0] SEL_SHUTDOWN_NOTICE_WAIT = 3'h1;
  localparam logic [SEL_W-1:0] SEL_FORCED_CUTOFF_WAIT = 3'h2;
  localparam logic [SEL_W-1:0] SEL_BROWNOUT_NOTICE_WAIT = 3'h3;
  localparam logic [SEL_W-1:0] SEL_BROWNOUT_CUTOFF_WAIT = 3'h4;
  localparam logic [SEL_W-1:0] SEL_BATTERY_MIN_LEVEL = 3'h5;
  localparam int NUM_CFG = 6;

  // Reset values, seconds
  localparam logic [VAL_W-1:0] DEF_POWER_ON_WAIT = 16'h0002;
  localparam logic [VAL_W-1:0] DEF_SHUTDOWN_NOTICE_WAIT = 16'h0005;
  localparam logic [VAL_W-1:0] DEF_FORCED_CUTOFF_WAIT = 16'h003C;
  localparam logic [VAL_W-1:0] DEF_BROWNOUT_NOTICE_WAIT = 16'h001E;
  localparam logic [VAL_W-1:0] DEF_BROWNOUT_CUTOFF_WAIT = 16'h003C;

  // Accepted wait spans, seconds
  localparam logic [VAL_W-1:0] WAIT_MIN = 16'h0001;
  localparam logic [VAL_W-1:0] LONG_WAIT_MAX = 16'h4650;
  localparam logic [VAL_W-1:0] SHORT_WAIT_MAX = 16'h0E10;

  // Battery threshold, millivolts
  localparam logic [VAL_W-1:0] DEF_LEVEL_12V = 16'h2C9C;
  localparam logic [VAL_W-1:0] MIN_LEVEL_12V = 16'h276A;
  localparam logic [VAL_W-1:0] MAX_LEVEL_12V = 16'h2FDA;
  localparam logic [VAL_W-1:0] DEF_LEVEL_24V = 16'h57A8;
  localparam logic [VAL_W-1:0] MIN_LEVEL_24V = 16'h5276;
  localparam logic [VAL_W-1:0] MAX_LEVEL_24V = 16'h5AF0;

  // Cycles after reset release before the supply mode strap is trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0] {IG_OFF, IG_ON_WAIT, IG_RUN, IG_NOTICE, IG_HARD} ig_state_t;
  typedef enum logic [1:0] {BT_IDLE, BT_NOTICE, BT_HARD} bt_state_t;

endpackage

//--- vehicle_power_supervisor.sv
// Vehicle power supervisor: ignition and low-battery power sequencing
`timescale 1ns/1ps
module vehicle_power_supervisor #(
  parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
  input wire logic SYS_CLK, // 100 MHz always-on clock
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic IGN_IN, // Ignition pin, high when on
  input wire logic MODE_24V, // Supply mode strap, high for 24 V
  input wire logic [15:0] BATT_MV, // Battery voltage in mV from converter
  input wire logic CFG_WR, // Parameter write strobe
  input wire logic [2:0] CFG_SEL, // Parameter select
  input wire logic [15:0] CFG_WDATA, // Parameter write value
  output logic [15:0] CFG_RDATA, // Selected parameter value
  output logic CFG_ERR, // Pulse: write refused as out of range
  output logic SYS_PWR_EN, // System power switch
  output logic PWR_LED, // Power indicator
  output logic PWRBTN_EVT // Pulse: power-button event to host
);
  localparam int VW = supervisor_pkg::VAL_W;

  logic [1:0] ign_sync_r;
  logic [1:0] mode_sync_r;
  logic ign;
  logic mode24;
  logic [1:0] settle_r;
  logic [VW-1:0] cfg_r [supervisor_pkg::NUM_CFG];
  supervisor_pkg::ig_state_t ig_state_r;
  supervisor_pkg::bt_state_t bt_state_r;
  logic armed_r;
  logic batt_low;
  logic batt_high;
  logic ig_evt;
  logic bt_evt;
  logic cut;
  logic [VW-1:0] ig_val_nxt;
  logic [VW-1:0] bt_val_nxt;
  logic ig_load_nxt;
  logic bt_load_nxt;

  countdown_if ig_cd ();
  countdown_if bt_cd ();

  // Accept a write only inside the documented span
  function automatic logic in_range(input logic [2:0] sel, input logic [VW-1:0] val, input logic m24);
    logic [VW-1:0] lo;
    logic [VW-1:0] hi;
    lo = supervisor_pkg::WAIT_MIN;
    hi = supervisor_pkg::LONG_WAIT_MAX;
    unique case (sel)
      supervisor_pkg::SEL_BROWNOUT_NOTICE_WAIT,
      supervisor_pkg::SEL_BROWNOUT_CUTOFF_WAIT: begin
        hi = supervisor_pkg::SHORT_WAIT_MAX;
      end
      supervisor_pkg::SEL_BATTERY_MIN_LEVEL: begin
        lo = m24 ? supervisor_pkg::MIN_LEVEL_24V : supervisor_pkg::MIN_LEVEL_12V;
        hi = m24 ? supervisor_pkg::MAX_LEVEL_24V : supervisor_pkg::MAX_LEVEL_12V;
      end
      default: begin
      end
    endcase
    return (sel < 3'(supervisor_pkg::NUM_CFG)) && (val >= lo) && (val <= hi);
  endfunction

  // Pin synchronisers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ign_sync_r <= 2'b00;
      mode_sync_r <= 2'b00;
    end else begin
      ign_sync_r <= {ign_sync_r[0], IGN_IN};
      mode_sync_r <= {mode_sync_r[0], MODE_24V};
    end
  end
  assign ign = ign_sync_r[1];
  assign mode24 = mode_sync_r[1];

  // Strap settling counter after reset release
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_r <= 2'b00;
    end else if (settle_r != supervisor_pkg::STRAP_SETTLE) begin
      settle_r <= settle_r + 1'b1;
    end
  end

  // Parameter store with defaults and checked writes
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r[supervisor_pkg::SEL_POWER_ON_WAIT] <= supervisor_pkg::DEF_POWER_ON_WAIT;
      cfg_r[supervisor_pkg::SEL_SHUTDOWN_NOTICE_WAIT] <= supervisor_pkg::DEF_SHUTDOWN_NOTICE_WAIT;
      cfg_r[supervisor_pkg::SEL_FORCED_CUTOFF_WAIT] <= supervisor_pkg::DEF_FORCED_CUTOFF_WAIT;
      cfg_r[supervisor_pkg::SEL_BROWNOUT_NOTICE_WAIT] <= supervisor_pkg::DEF_BROWNOUT_NOTICE_WAIT;
      cfg_r[supervisor_pkg::SEL_BROWNOUT_CUTOFF_WAIT] <= supervisor_pkg::DEF_BROWNOUT_CUTOFF_WAIT;
      cfg_r[supervisor_pkg::SEL_BATTERY_MIN_LEVEL] <= supervisor_pkg::DEF_LEVEL_12V;
    end else if (settle_r == 2'h2 && mode24) begin
      cfg_r[supervisor_pkg::SEL_BATTERY_MIN_LEVEL] <= supervisor_pkg::DEF_LEVEL_24V;
    end else if (CFG_WR && in_range(CFG_SEL, CFG_WDATA, mode24)) begin
      cfg_r[CFG_SEL] <= CFG_WDATA;
    end
  end

  // Readback and refused-write flag
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_RDATA <= '0;
      CFG_ERR <= 1'b0;
    end else begin
      CFG_RDATA <= (CFG_SEL < 3'(supervisor_pkg::NUM_CFG)) ? cfg_r[CFG_SEL] : '0;
      CFG_ERR <= CFG_WR && !in_range(CFG_SEL, CFG_WDATA, mode24);
    end
  end

  // Battery comparison against the programmed level
  assign batt_low = BATT_MV < cfg_r[supervisor_pkg::SEL_BATTERY_MIN_LEVEL];
  assign batt_high = BATT_MV > cfg_r[supervisor_pkg::SEL_BATTERY_MIN_LEVEL];

  // Event and cutoff conditions
  assign ig_evt = (ig_state_r == supervisor_pkg::IG_NOTICE) && ig_cd.expired && !ign;
  assign bt_evt = (bt_state_r == supervisor_pkg::BT_NOTICE) && bt_cd.expired && !batt_high;
  assign cut = ((ig_state_r == supervisor_pkg::IG_HARD) && ig_cd.expired) ||
               ((bt_state_r == supervisor_pkg::BT_HARD) && bt_cd.expired);

  // Ignition countdown load requests
  always_comb begin
    ig_load_nxt = 1'b0;
    ig_val_nxt = cfg_r[supervisor_pkg::SEL_POWER_ON_WAIT];
    unique case (ig_state_r)
      supervisor_pkg::IG_OFF: begin
        ig_load_nxt = ign && armed_r;
      end
      supervisor_pkg::IG_RUN: begin
        ig_load_nxt = !ign && !cut;
        ig_val_nxt = cfg_r[supervisor_pkg::SEL_SHUTDOWN_NOTICE_WAIT];
      end
      supervisor_pkg::IG_NOTICE: begin
        ig_load_nxt = ign || ig_evt;
        ig_val_nxt = ign ? cfg_r[supervisor_pkg::SEL_SHUTDOWN_NOTICE_WAIT]
                         : cfg_r[supervisor_pkg::SEL_FORCED_CUTOFF_WAIT];
      end
      default: begin
      end
    endcase
  end

  // Brownout countdown load requests
  always_comb begin
    bt_load_nxt = 1'b0;
    bt_val_nxt = cfg_r[supervisor_pkg::SEL_BROWNOUT_NOTICE_WAIT];
    unique case (bt_state_r)
      supervisor_pkg::BT_IDLE: begin
        bt_load_nxt = SYS_PWR_EN && batt_low && !cut;
      end
      supervisor_pkg::BT_NOTICE: begin
        bt_load_nxt = bt_evt;
        bt_val_nxt = cfg_r[supervisor_pkg::SEL_BROWNOUT_CUTOFF_WAIT];
      end
      default: begin
      end
    endcase
  end

  assign ig_cd.load = ig_load_nxt;
  assign ig_cd.load_val = ig_val_nxt;
  assign ig_cd.run = (ig_state_r != supervisor_pkg::IG_OFF) && (ig_state_r != supervisor_pkg::IG_RUN);
  assign bt_cd.load = bt_load_nxt;
  assign bt_cd.load_val = bt_val_nxt;
  assign bt_cd.run = bt_state_r != supervisor_pkg::BT_IDLE;

  // Ignition sequencer
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ig_state_r <= supervisor_pkg::IG_OFF;
    end else if (cut) begin
      ig_state_r <= supervisor_pkg::IG_OFF;
    end else begin
      unique case (ig_state_r)
        supervisor_pkg::IG_OFF: begin
          if (ign && armed_r) begin
            ig_state_r <= supervisor_pkg::IG_ON_WAIT;
          end
        end
        supervisor_pkg::IG_ON_WAIT: begin
          if (!ign) begin
            ig_state_r <= supervisor_pkg::IG_OFF;
          end else if (ig_cd.expired) begin
            ig_state_r <= supervisor_pkg::IG_RUN;
          end
        end
        supervisor_pkg::IG_RUN: begin
          if (!ign) begin
            ig_state_r <= supervisor_pkg::IG_NOTICE;
          end
        end
        supervisor_pkg::IG_NOTICE: begin
          if (ign) begin
            ig_state_r <= supervisor_pkg::IG_RUN;
          end else if (ig_cd.expired) begin
            ig_state_r <= supervisor_pkg::IG_HARD;
          end
        end
        supervisor_pkg::IG_HARD: begin
          ig_state_r <= supervisor_pkg::IG_HARD;
        end
      endcase
    end
  end

  // Low-battery sequencer
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bt_state_r <= supervisor_pkg::BT_IDLE;
    end else if (cut || !SYS_PWR_EN) begin
      bt_state_r <= supervisor_pkg::BT_IDLE;
    end else begin
      unique case (bt_state_r)
        supervisor_pkg::BT_IDLE: begin
          if (batt_low) begin
            bt_state_r <= supervisor_pkg::BT_NOTICE;
          end
        end
        supervisor_pkg::BT_NOTICE: begin
          if (batt_high) begin
            bt_state_r <= supervisor_pkg::BT_IDLE;
          end else if (bt_cd.expired) begin
            bt_state_r <= supervisor_pkg::BT_HARD;
          end
        end
        supervisor_pkg::BT_HARD: begin
          bt_state_r <= supervisor_pkg::BT_HARD;
        end
      endcase
    end
  end

  // Re-arm power-up only after ignition has been seen off
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      armed_r <= 1'b1;
    end else if (!ign) begin
      armed_r <= 1'b1;
    end else if (cut) begin
      armed_r <= 1'b0;
    end
  end

  // Power switch, indicator and host event
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SYS_PWR_EN <= 1'b0;
      PWR_LED <= 1'b0;
      PWRBTN_EVT <= 1'b0;
    end else begin
      if (cut) begin
        SYS_PWR_EN <= 1'b0;
      end else if (ig_state_r == supervisor_pkg::IG_ON_WAIT && ign && ig_cd.expired) begin
        SYS_PWR_EN <= 1'b1;
      end
      PWR_LED <= SYS_PWR_EN && !cut && (ig_state_r != supervisor_pkg::IG_HARD) &&
                 (bt_state_r != supervisor_pkg::BT_HARD);
      PWRBTN_EVT <= !cut && (ig_evt || bt_evt);
    end
  end

  // Per-path second ticks and countdowns
  second_tick #(.TICK_CYCLES(TICK_CYCLES)) ig_tick (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .cd(ig_cd.ticker)
  );
  countdown_timer ig_timer (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .cd(ig_cd.timer)
  );
  second_tick #(.TICK_CYCLES(TICK_CYCLES)) bt_tick (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .cd(bt_cd.ticker)
  );
  countdown_timer bt_timer (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .cd(bt_cd.timer)
  );
endmodule

//--- vehicle_power_supervisor_checker.sv
// Port checks of the vehicle power supervisor
`timescale 1ns/1ps
module vehicle_power_supervisor_checker #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic SYS_CLK, // Clock
  input wire logic RST_N, // Reset, active low
  input wire logic IGN_IN, // Ignition
  input wire logic MODE_24V, // Mode strap
  input wire logic [15:0] BATT_MV, // Battery mV
  input wire logic CFG_WR, // Write strobe
  input wire logic [2:0] CFG_SEL, // Select
  input wire logic [15:0] CFG_WDATA, // Write value
  input wire logic [15:0] CFG_RDATA, // Read value
  input wire logic CFG_ERR, // Refusal pulse
  input wire logic SYS_PWR_EN, // Power switch
  input wire logic PWR_LED, // Indicator
  input wire logic PWRBTN_EVT // Event pulse
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // Cycles powered since the last power-up
  int unsigned on_cnt_r;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      on_cnt_r <= 0;
    end else if (!SYS_PWR_EN) begin
      on_cnt_r <= 0;
    end else begin
      on_cnt_r <= on_cnt_r + 1;
    end
  end

  // Indicator, event, refusal, readback and cutoff-time relations
  property p_led_pwr; PWR_LED |-> SYS_PWR_EN; endproperty
  a_led_pwr: assert property (p_led_pwr) else $error("indicator lit without power");
  property p_led_on; $rose(SYS_PWR_EN) |=> PWR_LED; endproperty
  a_led_on: assert property (p_led_on) else $error("indicator dark after power-up");
  property p_evt_pulse; PWRBTN_EVT |=> !PWRBTN_EVT; endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than one cycle");
  property p_evt_led; PWRBTN_EVT |-> ##[0:2] !PWR_LED; endproperty
  a_evt_led: assert property (p_evt_led) else $error("indicator stays lit in cutoff stage");
  property p_evt_pwr; PWRBTN_EVT |-> SYS_PWR_EN; endproperty
  a_evt_pwr: assert property (p_evt_pwr) else $error("event while unpowered");
  property p_bad_sel; CFG_WR && CFG_SEL[2:1] == 2'b11 |=> CFG_ERR; endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("unmapped write accepted");
  property p_zero; CFG_WR && CFG_SEL < 3'h5 && CFG_WDATA == 16'h0000 |=> CFG_ERR; endproperty
  a_zero: assert property (p_zero) else $error("zero wait accepted");
  property p_err_cause; CFG_ERR |-> $past(CFG_WR); endproperty
  a_err_cause: assert property (p_err_cause) else $error("refusal without write");
  property p_rd_unmapped; CFG_SEL[2:1] == 2'b11 |=> CFG_RDATA == 16'h0000; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_cut_time; $fell(SYS_PWR_EN) |-> on_cnt_r >= 2 * TICK_CYCLES; endproperty
  a_cut_time: assert property (p_cut_time) else $error("power cut too early");

  // Main scenarios reached
  c_evt: cover property (PWRBTN_EVT);
  c_cut: cover property ($fell(SYS_PWR_EN));
  c_err: cover property (CFG_ERR);
endmodule

bind vehicle_power_supervisor vehicle_power_supervisor_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .IGN_IN(IGN_IN), .MODE_24V(MODE_24V), .BATT_MV(BATT_MV), .CFG_WR(CFG_WR),
  .CFG_SEL(CFG_SEL), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_ERR(CFG_ERR), .SYS_PWR_EN(SYS_PWR_EN),
  .PWR_LED(PWR_LED), .PWRBTN_EVT(PWRBTN_EVT));

//--- vehicle_power_supervisor_tb.sv
// Self-checking testbench of the vehicle power supervisor
`timescale 1ns/1ps
module vehicle_power_supervisor_tb;
  localparam int TK = 10;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic IGN_IN = 1'b0;
  logic MODE_24V = 1'b0;
  logic [15:0] BATT_MV = 16'h2EE0;
  logic CFG_WR = 1'b0;
  logic [2:0] CFG_SEL = 3'h0;
  logic [15:0] CFG_WDATA = 16'h0000;
  logic [15:0] CFG_RDATA;
  logic CFG_ERR;
  logic SYS_PWR_EN;
  logic PWR_LED;
  logic PWRBTN_EVT;
  logic [7:0] evt_cnt;
  logic [15:0] defs [6] = '{16'h0002, 16'h0005, 16'h003C, 16'h001E, 16'h003C, 16'h2C9C};
  int err_total = 0;
  int n_tests = 0;
  int n;

  vehicle_power_supervisor #(.TICK_CYCLES(TK)) i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .IGN_IN(IGN_IN),
    .MODE_24V(MODE_24V), .BATT_MV(BATT_MV), .CFG_WR(CFG_WR), .CFG_SEL(CFG_SEL), .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA(CFG_RDATA), .CFG_ERR(CFG_ERR), .SYS_PWR_EN(SYS_PWR_EN), .PWR_LED(PWR_LED), .PWRBTN_EVT(PWRBTN_EVT));
  host_model i_host (.clk(SYS_CLK), .rst_n(RST_N), .pwr_en(SYS_PWR_EN), .evt(PWRBTN_EVT), .evt_cnt(evt_cnt));

  // 100 MHz clock
  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge SYS_CLK);
  endtask

  // One write, refusal flag checked, then an idle cycle
  task automatic cfg_wr(input logic [2:0] sel, input logic [15:0] d, input logic err);
    CFG_SEL = sel;
    CFG_WDATA = d;
    CFG_WR = 1'b1;
    @(negedge SYS_CLK);
    CFG_WR = 1'b0;
    check(16'(CFG_ERR), 16'(err));
    @(negedge SYS_CLK);
  endtask

  task automatic cfg_rd(input logic [2:0] sel, input logic [15:0] exp);
    CFG_SEL = sel;
    cycles(2);
    check(CFG_RDATA, exp);
  endtask

  // Bounded wait on power (0) or event (1), delay checked against a window
  task automatic wait_for(input int w, input logic v, input int lo, input int hi);
    n = 0;
    while (n <= hi && (w == 0 ? SYS_PWR_EN : PWRBTN_EVT) !== v) begin
      @(negedge SYS_CLK);
      n++;
    end
    check(16'(n >= lo && n <= hi), 16'h0001);
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    cycles(12);
    RST_N = 1'b1;
    cycles(6);
    for (int i = 0; i < 6; i++) cfg_rd(3'(i), defs[i]);
    cfg_wr(3'h0, 16'h0000, 1'b1);
    cfg_wr(3'h2, 16'h4651, 1'b1);
    cfg_wr(3'h1, 16'h4650, 1'b0);
    cfg_wr(3'h3, 16'h0E11, 1'b1);
    cfg_wr(3'h4, 16'h0E10, 1'b0);
    cfg_wr(3'h5, 16'h2769, 1'b1);
    cfg_wr(3'h5, 16'h2FDB, 1'b1);
    cfg_wr(3'h6, 16'h0001, 1'b1);
    cfg_rd(3'h2, 16'h003C);
    cfg_rd(3'h1, 16'h4650);
    cfg_rd(3'h4, 16'h0E10);
    cfg_rd(3'h7, 16'h0000);
    for (int i = 0; i < 5; i++) cfg_wr(3'(i), 16'h0002, 1'b0);
    cfg_wr(3'h5, 16'h276A, 1'b0);
    cfg_rd(3'h5, 16'h276A);
    // Early ignition loss abandons power-up
    IGN_IN = 1'b1;
    cycles(10);
    IGN_IN = 1'b0;
    cycles(40);
    check(16'(SYS_PWR_EN), 16'h0000);
    IGN_IN = 1'b1;
    wait_for(0, 1'b1, 20, 30);
    cycles(2);
    check(16'(PWR_LED), 16'h0001);
    // Notice wait reloaded, then irreversible cutoff
    IGN_IN = 1'b0;
    cycles(12);
    IGN_IN = 1'b1;
    cycles(5);
    check(16'(evt_cnt), 16'h0000);
    IGN_IN = 1'b0;
    wait_for(1, 1'b1, 20, 30);
    IGN_IN = 1'b1;
    cycles(3);
    check(16'(PWR_LED), 16'h0000);
    wait_for(0, 1'b0, 12, 25);
    check(16'(evt_cnt), 16'h0001);
    // Re-arm, power up, then low battery
    IGN_IN = 1'b0;
    cycles(5);
    IGN_IN = 1'b1;
    wait_for(0, 1'b1, 20, 30);
    BATT_MV = 16'h2710;
    cycles(12);
    BATT_MV = 16'h2EE0;
    cycles(30);
    check(16'(evt_cnt), 16'h0001);
    check(16'(PWR_LED), 16'h0001);
    BATT_MV = 16'h2710;
    wait_for(1, 1'b1, 19, 28);
    BATT_MV = 16'h2EE0;
    wait_for(0, 1'b0, 17, 25);
    check(16'(evt_cnt), 16'h0002);
    check(16'(PWR_LED), 16'h0000);
    // Ignition still high after the cut: no re-power until seen low
    cycles(40);
    check(16'(SYS_PWR_EN), 16'h0000);
    // Second reset in 24 V mode
    RST_N = 1'b0;
    MODE_24V = 1'b1;
    cycles(3);
    check(16'(SYS_PWR_EN), 16'h0000);
    check(16'(PWR_LED), 16'h0000);
    RST_N = 1'b1;
    cycles(6);
    cfg_rd(3'h5, 16'h57A8);
    cfg_wr(3'h5, 16'h5AF1, 1'b1);
    cfg_wr(3'h5, 16'h5276, 1'b0);
    cfg_rd(3'h5, 16'h5276);
    report_and_stop();
  end
endmodule
